// [spi_mode_and_status.sv]
// Decided for this implementation: the plain strobed port.
module spi_mode_and_status (
	input  wire logic                            core_clk,
	input  wire logic                            reset,
	input  wire logic [spi_mode_pkg::ADDR_W-1:0] addr,
	input  wire logic [7:0]                      wdata,
	input  wire logic                            wr_en,
	input  wire logic                            rd_en,
	output logic      [7:0]                      rdata,
	input  wire logic                            sck_i,
	output logic                                 sck_o,
	output logic                                 sck_oe,
	input  wire logic                            mosi_i,
	output logic                                 mosi_o,
	output logic                                 mosi_oe,
	input  wire logic                            miso_i,
	output logic                                 miso_o,
	output logic                                 miso_oe,
	input  wire logic                            ss_i,
	output logic                                 ss_o,
	output logic                                 ss_oe
);
	import spi_mode_pkg::*;

	logic [3:0]  pin_in;
	logic [3:0]  sync1_q;
	logic [3:0]  sync2_q;
	logic        sck_s;
	logic        mosi_s;
	logic        miso_s;
	logic        ss_s;
	logic        sck_prev_q;
	logic        ss_prev_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  mode_q;
	logic [15:0] rate_q;
	logic        sel_value_q;
	logic [7:0]  tx_hold_q;
	logic        tx_full_q;
	logic [7:0]  rx_data_q;
	logic        rx_full_q;
	logic        under_q;
	logic        coll_q;
	logic        abort_q;
	logic        over_q;
	xfer_state_t state_q;
	logic [15:0] div_q;
	logic        sck_q;
	logic [3:0]  bit_q;
	logic [7:0]  shift_q;
	logic        tx_bit_q;
	logic        stop_q;
	logic        ss_lvl_q;
	logic [16:0] idle_cnt_q;
	logic        done_q;
	logic [7:0]  done_data_q;
	logic        under_ev_q;
	logic        abort_ev_q;
	logic        coll_ev_q;
	logic        fill_q;
	logic [7:0]  rdata_q;
	logic        sck_o_q;
	logic        sck_oe_q;
	logic        mosi_o_q;
	logic        mosi_oe_q;
	logic        miso_o_q;
	logic        miso_oe_q;
	logic        ss_o_q;
	logic        ss_oe_q;

	logic [1:0]  en;
	logic        enabled;
	logic        master;
	logic        rate_ctl;
	logic [2:0]  frame;
	logic [3:0]  nbits;
	logic        ss_dir;
	logic        ss_pol;
	logic        ss_act;
	logic        ss_edge;
	logic        sck_rise;
	logic        sck_fall;
	logic        tick;
	logic        rx_in;
	logic        in_bit;
	logic [7:0]  shifted;
	logic [7:0]  char_mask;
	logic        tx_avail;
	logic [7:0]  tx_word;
	logic        partial;
	logic        timeout;
	logic        coll_now;
	logic        slave_start;
	logic        pin_level;
	logic        wr_ctrl;
	logic        wr_data;
	logic        wr_txcmd;
	logic        wr_mode;
	logic        wr_stat;
	logic        rd_data;
	logic [7:0]  stat_word;
	logic [7:0]  rd_mux;

	assign pin_in = {sck_i, mosi_i, miso_i, ss_i};

	// Two flip-flops per pin before any logic looks at it.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge reset) begin
				// SS idles high, so its stages start high and no false edge follows reset.
				if (reset) begin
					sync1_q[gi] <= (gi == 0);
					sync2_q[gi] <= (gi == 0);
				end else begin
					sync1_q[gi] <= pin_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign sck_s  = sync2_q[3];
	assign mosi_s = sync2_q[2];
	assign miso_s = sync2_q[1];
	assign ss_s   = sync2_q[0];

	assign en        = {ctrl_q[CTL_EN1_BIT], ctrl_q[CTL_EN0_BIT]};
	assign enabled   = (en != EN_OFF);
	assign master    = ctrl_q[CTL_MASTER_BIT];
	assign rate_ctl  = ctrl_q[CTL_RATE_BIT];
	assign frame     = mode_q[MODE_FRAME_LSB +: 3];
	assign nbits     = (mode_q[MODE_LEN_LSB +: 3] == 3'h0) ? 4'h8 : {1'b0, mode_q[MODE_LEN_LSB +: 3]};
	assign ss_dir    = mode_q[MODE_DIR_BIT];
	assign ss_pol    = mode_q[MODE_POL_BIT];
	assign ss_act    = (ss_s == ss_pol);
	assign ss_edge   = (ss_s != ss_prev_q);
	assign sck_rise  = sck_s & ~sck_prev_q;
	assign sck_fall  = ~sck_s & sck_prev_q;
	assign tick      = (div_q == 16'(rate_q - 16'h0001));
	assign rx_in     = (frame == FRAME_LOOP) ? tx_bit_q : miso_s;
	assign in_bit    = master ? rx_in : mosi_s;
	assign shifted   = {shift_q[6:0], in_bit};
	assign char_mask = ALL_ONES >> (4'h8 - nbits);
	assign tx_avail  = tx_full_q && (en != EN_RX_ONLY);
	assign tx_word   = tx_avail ? (tx_hold_q << (4'h8 - nbits)) : ALL_ONES;
	assign partial   = (bit_q != nbits);
	assign timeout   = rate_ctl && partial && (idle_cnt_q == 17'({rate_q, 1'b0} - 17'h0_0001));
	assign coll_now  = master && !ss_dir && ss_act;
	assign slave_start = (frame == FRAME_SYNC) ? ss_edge : ss_act;

	assign wr_ctrl  = wr_en && (addr == CTRL_ADDR);
	assign wr_data  = wr_en && (addr == DATA_ADDR);
	assign wr_txcmd = wr_en && (addr == TXCMD_ADDR);
	assign wr_mode  = wr_en && (addr == MODE_ADDR);
	assign wr_stat  = wr_en && (addr == STAT_ADDR);
	assign rd_data  = rd_en && (addr == DATA_ADDR);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sck_prev_q <= 1'b0;
			ss_prev_q  <= 1'b1;
		end else begin
			sck_prev_q <= sck_s;
			ss_prev_q  <= ss_s;
		end
	end

	// Configuration registers.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET;
			mode_q <= MODE_RESET;
			rate_q <= RATE_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata;
			end
			if (wr_mode) begin
				mode_q <= wdata;
			end
			if (wr_en && addr == RATE_HI_ADDR) begin
				rate_q[15:8] <= wdata;
			end
			if (wr_en && addr == RATE_LO_ADDR) begin
				rate_q[7:0] <= wdata;
			end
		end
	end

	// Shift engine for both master and slave roles.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			div_q       <= 16'h0000;
			sck_q       <= 1'b0;
			bit_q       <= 4'h0;
			shift_q     <= 8'h00;
			tx_bit_q    <= 1'b0;
			stop_q      <= 1'b0;
			ss_lvl_q    <= 1'b0;
			idle_cnt_q  <= 17'h0_0000;
			tx_hold_q   <= 8'h00;
			tx_full_q   <= 1'b0;
			sel_value_q <= 1'b0;
			done_q      <= 1'b0;
			done_data_q <= 8'h00;
			under_ev_q  <= 1'b0;
			abort_ev_q  <= 1'b0;
			coll_ev_q   <= 1'b0;
			fill_q      <= 1'b0;
		end else begin
			done_q     <= 1'b0;
			under_ev_q <= 1'b0;
			abort_ev_q <= 1'b0;
			coll_ev_q  <= 1'b0;
			div_q      <= tick ? 16'h0000 : 16'(div_q + 16'h0001);
			if (!enabled) begin
				state_q   <= ST_IDLE;
				sck_q     <= 1'b0;
				tx_full_q <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						sck_q      <= 1'b0;
						stop_q     <= 1'b0;
						idle_cnt_q <= 17'h0_0000;
						div_q      <= 16'h0000;
						fill_q     <= 1'b0;
						bit_q      <= nbits;
						if (master) begin
							if (coll_now) begin
								coll_ev_q <= 1'b1;
							end else if (tx_full_q) begin
								shift_q   <= tx_word;
								tx_bit_q  <= tx_word[7];
								tx_full_q <= 1'b0;
								ss_lvl_q  <= sel_value_q;
								if (frame == FRAME_SYNC && ss_lvl_q != sel_value_q) begin
									state_q <= ST_LEAD;
								end else begin
									state_q <= ST_SHIFT;
								end
							end
						end else if (slave_start) begin
							shift_q  <= tx_word;
							tx_bit_q <= tx_word[7];
							state_q  <= ST_SHIFT;
							if (tx_avail) begin
								tx_full_q <= 1'b0;
							end else if (en != EN_RX_ONLY) begin
								under_ev_q <= 1'b1;
							end
						end
					end
					ST_LEAD: begin
						if (coll_now) begin
							coll_ev_q <= 1'b1;
							state_q   <= ST_IDLE;
						end else if (tick) begin
							sck_q <= ~sck_q;
							if (sck_q) begin
								state_q <= ST_SHIFT;
							end
						end
					end
					ST_SHIFT: begin
						if (master) begin
							if (coll_now) begin
								coll_ev_q <= 1'b1;
								state_q   <= ST_IDLE;
							end else if (tick && !sck_q) begin
								sck_q   <= 1'b1;
								shift_q <= shifted;
								bit_q   <= 4'(bit_q - 4'h1);
								if (bit_q == 4'h1) begin
									done_q      <= 1'b1;
									done_data_q <= shifted & char_mask;
									bit_q       <= nbits;
									if (tx_full_q && !(frame == FRAME_SYNC && sel_value_q != ss_lvl_q)) begin
										shift_q   <= tx_word;
										tx_full_q <= 1'b0;
									end else begin
										stop_q <= 1'b1;
									end
								end
							end else if (tick && sck_q) begin
								sck_q    <= 1'b0;
								tx_bit_q <= shift_q[7];
								if (stop_q) begin
									state_q <= ST_IDLE;
									if (frame == FRAME_SPI) begin
										sel_value_q <= 1'b0;
									end
								end
							end
						end else begin
							idle_cnt_q <= 17'(idle_cnt_q + 17'h0_0001);
							if (frame != FRAME_SYNC && !ss_act) begin
								state_q    <= ST_IDLE;
								abort_ev_q <= partial;
							end else if (timeout) begin
								state_q    <= ST_IDLE;
								abort_ev_q <= 1'b1;
							end else if (frame == FRAME_SYNC && ss_edge) begin
								bit_q      <= nbits;
								idle_cnt_q <= 17'h0_0000;
							end else if (sck_rise) begin
								idle_cnt_q <= 17'h0_0000;
								shift_q    <= shifted;
								bit_q      <= 4'(bit_q - 4'h1);
								fill_q     <= 1'b0;
								// A fill loaded at a character end is an underrun only once it is clocked.
								if (fill_q && bit_q == nbits) begin
									under_ev_q <= 1'b1;
								end
								if (bit_q == 4'h1) begin
									done_q      <= 1'b1;
									done_data_q <= shifted & char_mask;
									bit_q       <= nbits;
									shift_q     <= tx_word;
									if (tx_avail) begin
										tx_full_q <= 1'b0;
									end else begin
										fill_q <= (en != EN_RX_ONLY);
									end
								end
							end else if (sck_fall) begin
								idle_cnt_q <= 17'h0_0000;
								tx_bit_q   <= shift_q[7];
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
			if (wr_txcmd) begin
				sel_value_q <= wdata[0];
			end
			if (wr_data) begin
				tx_hold_q <= wdata;
				tx_full_q <= 1'b1;
			end
		end
	end

	// Status flags; a hardware set wins over a software clear.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_data_q <= 8'h00;
			rx_full_q <= 1'b0;
			under_q   <= 1'b0;
			coll_q    <= 1'b0;
			abort_q   <= 1'b0;
			over_q    <= 1'b0;
		end else if (!enabled) begin
			rx_full_q <= 1'b0;
			under_q   <= 1'b0;
			coll_q    <= 1'b0;
			abort_q   <= 1'b0;
			over_q    <= 1'b0;
		end else begin
			if (wr_stat) begin
				under_q <= under_q & ~wdata[ST_UND_BIT];
				coll_q  <= coll_q & ~wdata[ST_COL_BIT];
				abort_q <= abort_q & ~wdata[ST_ABT_BIT];
				over_q  <= over_q & ~wdata[ST_OVR_BIT];
			end
			if (rd_data) begin
				rx_full_q <= 1'b0;
			end
			if (under_ev_q) begin
				under_q <= 1'b1;
			end
			if (coll_ev_q) begin
				coll_q <= 1'b1;
			end
			if (abort_ev_q) begin
				abort_q <= 1'b1;
			end
			if (done_q && en != EN_TX_ONLY) begin
				rx_data_q <= done_data_q;
				rx_full_q <= 1'b1;
				if (rx_full_q && !rd_data) begin
					over_q <= 1'b1;
				end
			end
		end
	end

	assign pin_level = ss_oe_q ? ss_o_q : ss_s;
	assign stat_word = {(!enabled || (!tx_full_q && en != EN_RX_ONLY)), under_q,
		coll_q, abort_q, over_q, rx_full_q, state_q != ST_IDLE,
		enabled ? pin_level : STAT_RESET[0]};

	always_comb begin
		case (addr)
			CTRL_ADDR:    rd_mux = ctrl_q;
			DATA_ADDR:    rd_mux = rx_data_q;
			TXCMD_ADDR:   rd_mux = {7'h00, sel_value_q};
			MODE_ADDR:    rd_mux = mode_q;
			STAT_ADDR:    rd_mux = stat_word;
			RATE_HI_ADDR: rd_mux = rate_q[15:8];
			RATE_LO_ADDR: rd_mux = rate_q[7:0];
			default:      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_en ? rd_mux : 8'h00;
		end
	end

	// Pin drivers, registered.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sck_o_q   <= 1'b0;
			sck_oe_q  <= 1'b0;
			mosi_o_q  <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_o_q  <= 1'b0;
			miso_oe_q <= 1'b0;
			ss_o_q    <= 1'b1;
			ss_oe_q   <= 1'b0;
		end else begin
			sck_oe_q  <= enabled && master && frame != FRAME_LOOP;
			mosi_oe_q <= enabled && master && frame != FRAME_LOOP;
			sck_o_q   <= sck_q;
			mosi_o_q  <= tx_bit_q;
			miso_oe_q <= enabled && !master && (frame == FRAME_SYNC || ss_act);
			miso_o_q  <= (frame == FRAME_LOOP) ? mosi_s : tx_bit_q;
			ss_oe_q   <= enabled && ss_dir && !(master && frame == FRAME_LOOP);
			if (frame == FRAME_SYNC) begin
				ss_o_q <= ss_pol ? ss_lvl_q : ~ss_lvl_q;
			end else begin
				ss_o_q <= ss_pol ? sel_value_q : ~sel_value_q;
			end
		end
	end

	assign rdata   = rdata_q;
	assign sck_o   = sck_o_q;
	assign sck_oe  = sck_oe_q;
	assign mosi_o  = mosi_o_q;
	assign mosi_oe = mosi_oe_q;
	assign miso_o  = miso_o_q;
	assign miso_oe = miso_oe_q;
	assign ss_o    = ss_o_q;
	assign ss_oe   = ss_oe_q;

endmodule

// [spi_mode_pkg.sv]
// Behaviour
// - Mode field picks SPI, loopback or synchronous.
// - SPI framing drives SS from select value.
// - SPI framing clears select value after the last character.
// - SPI framing clocks only while bits move.
// - Master loopback silences pins, loops data internally.
// - Slave loopback echoes MOSI onto MISO.
// - Synchronous master leads a frame by one period when the select value changes the SS level.
// - Synchronous master clocks frames back to back.
// - Synchronous slave restarts on any SS change.
// - Length code zero means eight bits.
// - Direction bit makes SS input or output.
// - Polarity bit sets SS active level.
// - Disabled port returns status to reset.
// - Error flags clear by writing one.
// - Transmit empty reflects holding register state; receive-only mode reads it as 0.
// - Slave abort on early SS deassertion.
// - Slave abort on SCK monitor timeout.
// - Collision flag on multi-master mode fault.
// - Overrun and underrun flags mark errors.
// - Receive flag shows unread data present.
// - Busy flag and SS level readable.
// - Master bit swaps data pins, SCK direction.
// - Enable field selects off, rx, tx, duplex.
// - Rate generator makes SCK or monitors it.
package spi_mode_pkg;

	localparam int          ADDR_W          = 12;
	localparam logic [11:0] CTRL_ADDR       = 12'hf60;
	localparam logic [11:0] DATA_ADDR       = 12'hf61;
	localparam logic [11:0] TXCMD_ADDR      = 12'hf62;
	localparam logic [11:0] MODE_ADDR       = 12'hf63;
	localparam logic [11:0] STAT_ADDR       = 12'hf64;
	localparam logic [11:0] RATE_HI_ADDR    = 12'hf66;
	localparam logic [11:0] RATE_LO_ADDR    = 12'hf67;

	localparam int          CTL_EN1_BIT     = 6;
	localparam int          CTL_RATE_BIT    = 5;
	localparam int          CTL_MASTER_BIT  = 1;
	localparam int          CTL_EN0_BIT     = 0;
	localparam int          MODE_FRAME_LSB  = 5;
	localparam int          MODE_LEN_LSB    = 2;
	localparam int          MODE_DIR_BIT    = 1;
	localparam int          MODE_POL_BIT    = 0;
	localparam int          ST_TXE_BIT      = 7;
	localparam int          ST_UND_BIT      = 6;
	localparam int          ST_COL_BIT      = 5;
	localparam int          ST_ABT_BIT      = 4;
	localparam int          ST_OVR_BIT      = 3;

	localparam logic [2:0]  FRAME_SPI       = 3'h0;
	localparam logic [2:0]  FRAME_LOOP      = 3'h1;
	localparam logic [2:0]  FRAME_SYNC      = 3'h2;
	localparam logic [1:0]  EN_OFF          = 2'h0;
	localparam logic [1:0]  EN_RX_ONLY      = 2'h1;
	localparam logic [1:0]  EN_TX_ONLY      = 2'h2;

	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  MODE_RESET      = 8'h00;
	localparam logic [7:0]  STAT_RESET      = 8'h81;
	localparam logic [15:0] RATE_RESET      = 16'hffff;
	localparam logic [7:0]  ALL_ONES        = 8'hff;

	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} xfer_state_t;

endpackage

// [spi_mode_and_status_props.sv]
module spi_mode_and_status_props (
	input wire logic                            core_clk,
	input wire logic                            reset,
	input wire logic [spi_mode_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0]                      wdata,
	input wire logic                            wr_en,
	input wire logic                            rd_en,
	input wire logic [7:0]                      rdata,
	input wire logic                            sck_o,
	input wire logic                            sck_oe,
	input wire logic                            mosi_o,
	input wire logic                            mosi_oe,
	input wire logic                            miso_oe,
	input wire logic                            ss_o,
	input wire logic                            ss_oe
);
	import spi_mode_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [7:0] ctrl_q;
	logic [7:0] mode_q;
	logic [3:0] off_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) ctrl_q <= CTRL_RESET;
		else if (wr_en && addr == CTRL_ADDR) ctrl_q <= wdata;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) mode_q <= MODE_RESET;
		else if (wr_en && addr == MODE_ADDR) mode_q <= wdata;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) off_q <= 4'h0;
		else if (ctrl_q[CTL_EN1_BIT] || ctrl_q[CTL_EN0_BIT]) off_q <= 4'h0;
		else if (off_q != 4'hf) off_q <= off_q + 4'h1;
	end

	a_mode_readback: assert property (
		(wr_en && addr == MODE_ADDR) ##2 (rd_en && addr == MODE_ADDR) |=> rdata == $past(wdata, 3))
		else $error("mode register read back differs from last write");
	a_status_off: assert property (
		(rd_en && addr == STAT_ADDR && off_q > 4'h2) |=> rdata == STAT_RESET)
		else $error("status of disabled port is not the reset value");
	a_ss_direction: assert property (!mode_q[MODE_DIR_BIT] |=> !ss_oe)
		else $error("SS driven while configured as input");
	a_ss_polarity: assert property (
		(wr_en && addr == TXCMD_ADDR && wdata[0] && mode_q[7:5] == FRAME_SPI
		&& mode_q[MODE_DIR_BIT]) |-> ##[1:3] (ss_oe && ss_o == mode_q[MODE_POL_BIT]))
		else $error("SS level does not follow select value and polarity");
	a_loop_quiet: assert property (
		(ctrl_q[CTL_MASTER_BIT] && mode_q[7:5] == FRAME_LOOP) |=> !sck_oe && !mosi_oe)
		else $error("master loopback drives its pins");
	a_slave_inputs: assert property (!ctrl_q[CTL_MASTER_BIT] |=> !sck_oe && !mosi_oe)
		else $error("slave drives SCK or MOSI");
	a_master_no_miso: assert property (
		(ctrl_q[CTL_MASTER_BIT] && mode_q[7:5] != FRAME_SYNC) |=> !miso_oe)
		else $error("master drives MISO");
	a_mosi_on_low: assert property ((sck_oe && $changed(mosi_o)) |-> !sck_o)
		else $error("MOSI changed while SCK high");
	a_txe_write: assert property (
		(wr_en && addr == DATA_ADDR && ctrl_q[CTL_EN1_BIT] && !ctrl_q[CTL_MASTER_BIT])
		##2 (rd_en && addr == STAT_ADDR) |=> !rdata[ST_TXE_BIT])
		else $error("transmit empty still set after data write");

	c_sel_write: cover property (wr_en && addr == TXCMD_ADDR && wdata[0]);
	c_master_loop: cover property (ctrl_q[CTL_MASTER_BIT] && mode_q[7:5] == FRAME_LOOP);
	c_master_sck: cover property (sck_oe && $rose(sck_o));
endmodule

bind spi_mode_and_status spi_mode_and_status_props u_props (
	.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
	.mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_o(ss_o), .ss_oe(ss_oe)
);

// [spi_far_master.sv]
module spi_far_master (
	output logic      sck,
	output logic      mosi,
	output logic      ss_n,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam time HALF = 80ns;

	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end

	// Mode 0 frame: SCK idles low, bits MSB first; a short count cuts the frame early.
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
		r = 8'h00;
		ss_n = 1'b0;
		#HALF;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#HALF;
			sck = 1'b1;
			r[i] = miso;
			#HALF;
			sck = 1'b0;
		end
		#HALF;
		ss_n = 1'b1;
		mosi = ~mosi;
		// Deselect time, so SS has settled inside the block before the next look.
		#HALF;
	endtask

	// Sets SS to the given level, then gives n SCK pulses and parks SCK low.
	task automatic ss_clocks(input logic lvl, input int n);
		ss_n = lvl;
		for (int i = 0; i < n; i++) begin
			#HALF;
			sck = 1'b1;
			#HALF;
			sck = 1'b0;
		end
	endtask
endmodule

// [spi_mode_and_status_bench.sv]
module spi_mode_and_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_mode_pkg::*;
	logic        core_clk, reset, wr_en, rd_en;
	logic [11:0] addr;
	logic [7:0]  wdata, rdata;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
	logic        far_sck, far_mosi, far_ss_n;
	wire logic   sck_i, mosi_i, miso_i, ss_i;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_sck = 0;

	// Pin levels from all drivers; MISO falls back to MOSI as an echoing slave.
	assign sck_i = sck_oe ? sck_o : far_sck;
	assign mosi_i = mosi_oe ? mosi_o : far_mosi;
	assign miso_i = miso_oe ? miso_o : mosi_o;
	assign ss_i = ss_oe ? ss_o : far_ss_n;

	spi_mode_and_status u_dut (
		.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i),
		.miso_o(miso_o), .miso_oe(miso_oe), .ss_i(ss_i), .ss_o(ss_o), .ss_oe(ss_oe)
	);
	spi_far_master u_far (.sck(far_sck), .mosi(far_mosi), .ss_n(far_ss_n), .miso(miso_i));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge sck_o) n_sck++;

	task automatic print_verdict();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp_pin(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string what);
		logic [7:0] v;
		rd(a, v);
		cmp8(v, e, what);
	endtask
	task automatic wait_rx();
		logic [7:0] v;
		for (int i = 0; i < 400; i++) begin
			rd(STAT_ADDR, v);
			if (v[2] === 1'b1) return;
		end
		n_mismatch++;
		$display("Error at %0t: receive flag timeout", $time);
		print_verdict();
	endtask
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic t_reset();
		rchk(MODE_ADDR, MODE_RESET, "mode reset");
		rchk(STAT_ADDR, STAT_RESET, "status reset");
		wr(12'hf65, 8'hff);
		rchk(12'hf65, 8'h00, "unmapped read");
		wr(MODE_ADDR, 8'hfc);
		rchk(MODE_ADDR, 8'hfc, "mode read back");
		wr(MODE_ADDR, 8'h00);
	endtask
	task automatic t_slave();
		logic [7:0] r;
		wr(CTRL_ADDR, 8'h41);
		wr(DATA_ADDR, 8'h3c);
		rchk(STAT_ADDR, 8'h01, "tx full");
		u_far.xfer(8'ha5, 8, r);
		cmp8(r, 8'h3c, "slave sent byte");
		rchk(STAT_ADDR, 8'h85, "rx ready");
		u_far.xfer(8'h5a, 8, r);
		cmp8(r, 8'hff, "underrun fill");
		rchk(STAT_ADDR, 8'hcd, "underrun and overrun");
		rchk(DATA_ADDR, 8'h5a, "newest byte kept");
		rchk(STAT_ADDR, 8'hc9, "read clears rx flag");
		wr(STAT_ADDR, 8'h40);
		rchk(STAT_ADDR, 8'h89, "clear one flag");
		wr(STAT_ADDR, 8'h08);
		rchk(STAT_ADDR, 8'h81, "clear other flag");
	endtask
	task automatic t_abort();
		logic [7:0] r;
		logic [7:0] v;
		wr(MODE_ADDR, 8'h0c);
		u_far.xfer(8'h05, 3, r);
		rd(DATA_ADDR, v);
		cmp8(v & 8'h07, 8'h05, "three bit char");
		u_far.xfer(8'h00, 2, r);
		rchk(STAT_ADDR, 8'hd1, "abort on early SS");
		wr(CTRL_ADDR, 8'h00);
		rchk(STAT_ADDR, 8'h81, "disable resets flags");
	endtask
	task automatic t_slave_echo();
		logic [7:0] r;
		wr(CTRL_ADDR, 8'h41);
		wr(MODE_ADDR, 8'h20);
		u_far.xfer(8'h96, 8, r);
		cmp8(r, 8'h96, "slave echo");
		wr(CTRL_ADDR, 8'h00);
	endtask
	task automatic t_master_loop();
		wr(RATE_HI_ADDR, 8'h00);
		wr(RATE_LO_ADDR, 8'h02);
		wr(CTRL_ADDR, 8'h43);
		wr(DATA_ADDR, 8'h5a);
		wait_rx();
		rchk(DATA_ADDR, 8'h5a, "internal loop");
		cmp_pin(sck_oe | mosi_oe, 1'b0, "loop pins quiet");
	endtask
	task automatic t_master_spi();
		wr(RATE_LO_ADDR, 8'h10);
		wr(MODE_ADDR, 8'h02);
		wr(TXCMD_ADDR, 8'h01);
		settle();
		cmp_pin(ss_o, 1'b0, "SS active low");
		n_sck = 0;
		wr(DATA_ADDR, 8'hc3);
		wait_rx();
		rchk(DATA_ADDR, 8'hc3, "master byte");
		cmp8(8'(n_sck), 8'h08, "SCK pulses");
		for (int i = 0; i < 50 && ss_o !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		cmp_pin(ss_o, 1'b1, "SS released");
		wr(MODE_ADDR, 8'h03);
		wr(TXCMD_ADDR, 8'h01);
		settle();
		cmp_pin(ss_o, 1'b1, "SS active high");
		wr(TXCMD_ADDR, 8'h00);
		settle();
		rchk(STAT_ADDR, 8'h80, "SS level low");
	endtask
	task automatic t_faults();
		wr(MODE_ADDR, 8'h00);
		u_far.ss_clocks(1'b0, 0);
		settle();
		rchk(STAT_ADDR, 8'ha0, "collision on SS input");
		wr(CTRL_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h61);
		u_far.ss_clocks(1'b0, 3);
		repeat (40) @(posedge core_clk);
		rchk(STAT_ADDR, 8'hd2, "SCK monitor abort");
		wr(CTRL_ADDR, 8'h00);
		u_far.ss_clocks(1'b1, 0);
	endtask
	task automatic t_sync_master();
		wr(MODE_ADDR, 8'h42);
		wr(TXCMD_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h43);
		n_sck = 0;
		wr(DATA_ADDR, 8'ha6);
		wr(DATA_ADDR, 8'h3b);
		wait_rx();
		rchk(DATA_ADDR, 8'ha6, "sync first frame");
		wait_rx();
		rchk(DATA_ADDR, 8'h3b, "sync second frame");
		cmp8(8'(n_sck), 8'h11, "lead period plus two frames");
		cmp_pin(ss_o, 1'b1, "SS holds frame level");
	endtask

	initial begin
		reset = 1'b1;
		addr = 12'h000;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_slave();
		t_abort();
		t_slave_echo();
		t_master_loop();
		t_master_spi();
		t_faults();
		t_sync_master();
		print_verdict();
	end
endmodule
